/* core/twm_master.sv */
// Purpose: Two-wire bus master: start, repeated start, stop, byte write and read
// Assumes: Caller sequences commands; lines are open-drain with pull-ups
// Notes:   Device-select bytes for the serial memory are built here
//
// Summary of operation
// - The block only ever acts as bus master, never as a slave.
// - Bus counts as idle while clock and data lines are both high.
// - A start requested while idle issues a start condition.
// - Bus counts as busy from a start until a stop; the clock line is held low between commands.
// - A stop requested while busy generates a stop and frees the bus.
// - A start requested while busy gives a repeated start, no stop first.
// - Both lines are pulled low or released; pull-ups make the high level.
// - Pulses on either line shorter than 50 ns are ignored.
// - Any of 128 slave addresses can be sent as a raw byte.
// - Memory select byte carries 1010 then the three chip address bits.
// - Select byte direction bit is 1 for read, 0 for write.
// - Each eight-bit byte is followed by an acknowledge bit.
// - Memory write runs start, select, high, low address, data, stop.
// - After a memory write and stop, wait about 5 ms before reuse.
// - Random read: write select, address, repeated start, read select, data.
`default_nettype none

module twm_master
	import twm_pkg::*;
#(
	parameter int unsigned WR_HOLD_CYC = WRITE_CYCLE_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Command port
	input wire logic cmd_valid,
	input wire logic [2:0] cmd_code,
	input wire logic [7:0] cmd_data,
	input wire logic [2:0] cmd_chip,
	input wire logic cmd_ack_bit,
	output logic cmd_ready,
	output logic done,
	output logic nack,
	output logic [7:0] rd_data,
	// Status
	output logic bus_idle,
	output logic wr_busy,
	// Clock line
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_n,
	// Data line
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n
);

	localparam int WH_W = $clog2(WR_HOLD_CYC + 1);

	state_t state_q, state_d;
	logic [1:0] phase_q, phase_d;
	logic [7:0] qcnt_q, qcnt_d;
	logic [3:0] bit_q, bit_d;
	logic [7:0] sh_q, sh_d;
	logic rd_q, rd_d, ackbit_q, ackbit_d, ackv_q, ackv_d;
	logic busy_q, busy_d, wrsel_q, wrsel_d;
	logic scl_oe_n_q, scl_oe_n_d, sda_oe_n_q, sda_oe_n_d;
	logic done_q, done_d, nack_q, nack_d, ready_q, ready_d, idle_q, idle_d;
	logic [7:0] rd_data_q, rd_data_d;
	logic [WH_W-1:0] wh_q, wh_d;
	logic wrb_q, wrb_d;
	logic tick, scl_c, sda_c, idle_c, take, byte_c;
	cmd_t cmd;

	line_if lines ();

	// ----------------------------------------------------------------
	// Input filtering
	// ----------------------------------------------------------------
	assign lines.raw = {scl_in, sda_in};
	line_filter u_filter (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.lines(lines.filt)
	);
	assign scl_c = lines.clean[1];
	assign sda_c = lines.clean[0];
	assign idle_c = scl_c & sda_c;
	assign tick = (state_q != ST_IDLE) && (qcnt_q == QCNT_LAST);
	assign take = cmd_valid && ready_q;
	assign cmd = cmd_t'(cmd_code);
	assign byte_c = (cmd == CMD_WRITE) || (cmd == CMD_READ) || (cmd == CMD_SEL_WR) ||
		(cmd == CMD_SEL_RD);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Actions happen at the end of each quarter bit; phase 2 waits on a
	// released clock line so a slave holding it low stretches the bit
	always_comb begin
		state_d = state_q;
		phase_d = phase_q;
		bit_d = bit_q;
		sh_d = sh_q;
		rd_d = rd_q;
		ackbit_d = ackbit_q;
		ackv_d = ackv_q;
		busy_d = busy_q;
		wrsel_d = wrsel_q;
		scl_oe_n_d = scl_oe_n_q;
		sda_oe_n_d = sda_oe_n_q;
		done_d = 1'b0;
		nack_d = nack_q;
		rd_data_d = rd_data_q;
		wh_d = (wh_q != '0) ? wh_q - 1'b1 : wh_q;
		qcnt_d = (state_q == ST_IDLE || tick) ? 8'h00 : qcnt_q + 8'h01;
		unique case (state_q)
			ST_IDLE: begin
				if (take) begin
					phase_d = 2'h0;
					bit_d = 4'h0;
					unique case (cmd)
						CMD_START: state_d = ST_START;
						CMD_STOP: begin
							if (busy_q) begin
								state_d = ST_STOP;
							end else begin
								done_d = 1'b1;
							end
						end
						CMD_WRITE, CMD_SEL_WR, CMD_SEL_RD: begin
							// Raw bytes reach any 7-bit slave address
							sh_d = cmd_data;
							if (cmd == CMD_SEL_WR) begin
								sh_d = {MEM_SEL_TAG, cmd_chip, 1'b0};
							end
							if (cmd == CMD_SEL_RD) begin
								sh_d = {MEM_SEL_TAG, cmd_chip, 1'b1};
							end
							wrsel_d = wrsel_q | (cmd == CMD_SEL_WR);
							rd_d = 1'b0;
						end
						CMD_READ: begin
							sh_d = RD_RELEASE;
							rd_d = 1'b1;
							ackbit_d = cmd_ack_bit;
						end
						default: done_d = 1'b1;
					endcase
					// Byte moves are refused outside a transaction
					if (byte_c && !busy_q) begin
						state_d = ST_IDLE;
						done_d = 1'b1;
						nack_d = 1'b1;
						wrsel_d = wrsel_q;
					end else if (byte_c) begin
						// Byte moves inside a transaction start clocking out the byte
						state_d = ST_BIT;
					end
				end
			end
			ST_START: begin
				if (tick) begin
					phase_d = phase_q + 2'h1;
					unique case (phase_q)
						2'h0: begin
							sda_oe_n_d = 1'b1;
							// A fresh start waits for a truly idle bus
							if (!busy_q && !idle_c) begin
								phase_d = phase_q;
							end
						end
						2'h1: scl_oe_n_d = 1'b1;
						2'h2: begin
							if (scl_c) begin
								sda_oe_n_d = 1'b0;
							end else begin
								phase_d = phase_q;
							end
						end
						PH_LAST: begin
							scl_oe_n_d = 1'b0;
							if (!busy_q) begin
								wrsel_d = 1'b0;
							end
							busy_d = 1'b1;
							done_d = 1'b1;
							nack_d = 1'b0;
							state_d = ST_IDLE;
						end
					endcase
				end
			end
			ST_BIT: begin
				if (tick) begin
					phase_d = phase_q + 2'h1;
					unique case (phase_q)
						2'h0: begin
							if (bit_q == ACK_SLOT) begin
								sda_oe_n_d = rd_q ? ackbit_q : 1'b1;
							end else begin
								sda_oe_n_d = sh_q[7];
							end
						end
						2'h1: scl_oe_n_d = 1'b1;
						2'h2: begin
							if (!scl_c) begin
								phase_d = phase_q;
							end else if (bit_q == ACK_SLOT) begin
								ackv_d = sda_c;
							end else begin
								sh_d = {sh_q[6:0], sda_c};
							end
						end
						PH_LAST: begin
							scl_oe_n_d = 1'b0;
							bit_d = bit_q + 4'h1;
							if (bit_q == ACK_SLOT) begin
								done_d = 1'b1;
								nack_d = rd_q ? 1'b0 : ackv_q;
								rd_data_d = sh_q;
								state_d = ST_IDLE;
							end
						end
					endcase
				end
			end
			ST_STOP: begin
				if (tick) begin
					phase_d = phase_q + 2'h1;
					unique case (phase_q)
						2'h0: sda_oe_n_d = 1'b0;
						2'h1: scl_oe_n_d = 1'b1;
						2'h2: begin
							if (scl_c) begin
								sda_oe_n_d = 1'b1;
							end else begin
								phase_d = phase_q;
							end
						end
						PH_LAST: begin
							busy_d = 1'b0;
							done_d = 1'b1;
							nack_d = 1'b0;
							state_d = ST_IDLE;
							// Memory is deaf during its internal write
							if (wrsel_q) begin
								wh_d = WH_W'(WR_HOLD_CYC);
							end
							wrsel_d = 1'b0;
						end
					endcase
				end
			end
		endcase
		ready_d = (state_d == ST_IDLE) && (wh_d == '0) && !take;
		idle_d = idle_c && !busy_d;
		// Registered so the status pin comes straight from a flop
		wrb_d = (wh_d != '0);
	end

	// Register every next value; lines released at reset
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= ST_IDLE;
			phase_q <= 2'h0;
			qcnt_q <= 8'h00;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			rd_q <= 1'b0;
			ackbit_q <= 1'b1;
			ackv_q <= 1'b1;
			busy_q <= 1'b0;
			wrsel_q <= 1'b0;
			scl_oe_n_q <= 1'b1;
			sda_oe_n_q <= 1'b1;
			done_q <= 1'b0;
			nack_q <= 1'b0;
			rd_data_q <= 8'h00;
			ready_q <= 1'b0;
			idle_q <= 1'b0;
			wh_q <= '0;
			wrb_q <= 1'b0;
		end else begin
			state_q <= state_d;
			phase_q <= phase_d;
			qcnt_q <= qcnt_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			rd_q <= rd_d;
			ackbit_q <= ackbit_d;
			ackv_q <= ackv_d;
			busy_q <= busy_d;
			wrsel_q <= wrsel_d;
			scl_oe_n_q <= scl_oe_n_d;
			sda_oe_n_q <= sda_oe_n_d;
			done_q <= done_d;
			nack_q <= nack_d;
			rd_data_q <= rd_data_d;
			ready_q <= ready_d;
			idle_q <= idle_d;
			wh_q <= wh_d;
			wrb_q <= wrb_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Open drain: output level stays low, only the enables move
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe_n = scl_oe_n_q;
	assign sda_oe_n = sda_oe_n_q;
	assign cmd_ready = ready_q;
	assign done = done_q;
	assign nack = nack_q;
	assign rd_data = rd_data_q;
	assign bus_idle = idle_q;
	assign wr_busy = wrb_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	property p_no_drive_idle;
		(state_q == ST_IDLE && !busy_q) |-> (scl_oe_n_q && sda_oe_n_q);
	endproperty
	a_no_drive_idle: assert property (p_no_drive_idle)
		else $error("line driven outside a transaction");

	property p_wait_idle;
		(state_q == ST_START && phase_q == 2'h0 && !busy_q && !idle_c && tick)
			|=> (phase_q == 2'h0);
	endproperty
	a_wait_idle: assert property (p_wait_idle)
		else $error("start issued on a bus that was not idle");

	property p_start_edge;
		(state_q == ST_START && $fell(sda_oe_n_q)) |-> scl_oe_n_q;
	endproperty
	a_start_edge: assert property (p_start_edge)
		else $error("start edge without clock released");

	property p_busy_low;
		(busy_q && state_q == ST_IDLE) |-> !scl_oe_n_q;
	endproperty
	a_busy_low: assert property (p_busy_low)
		else $error("clock line released while busy and waiting");

	property p_stop_end;
		(state_q == ST_STOP && phase_q == PH_LAST && tick) |=> (!busy_q && done_q && sda_oe_n_q);
	endproperty
	a_stop_end: assert property (p_stop_end)
		else $error("stop did not free the bus");

	property p_sel_byte;
		(take && busy_q && cmd == CMD_SEL_RD) |=> (sh_q == {MEM_SEL_TAG, $past(cmd_chip), 1'b1});
	endproperty
	a_sel_byte: assert property (p_sel_byte)
		else $error("read select byte malformed");

	property p_byte_done;
		(state_q == ST_BIT && bit_q == ACK_SLOT && phase_q == PH_LAST && tick)
			|=> (done_q && state_q == ST_IDLE);
	endproperty
	a_byte_done: assert property (p_byte_done)
		else $error("ninth bit did not complete the byte");

	property p_hold;
		(state_q == ST_STOP && phase_q == PH_LAST && tick && wrsel_q)
			|=> (wr_busy && !cmd_ready) [*2];
	endproperty
	a_hold: assert property (p_hold)
		else $error("write cycle hold not started");

	property p_nack_rep;
		(state_q == ST_BIT && !rd_q && bit_q == ACK_SLOT && phase_q == PH_LAST && tick)
			|=> (nack_q == $past(ackv_q));
	endproperty
	a_nack_rep: assert property (p_nack_rep)
		else $error("acknowledge not reported");

	property p_rd_ack;
		(state_q == ST_BIT && rd_q && bit_q == ACK_SLOT && phase_q != 2'h0)
			|-> (sda_oe_n_q == ackbit_q);
	endproperty
	a_rd_ack: assert property (p_rd_ack)
		else $error("read acknowledge not the caller value");

	c_wr_byte: cover property (done_q && !rd_q && state_q == ST_IDLE && busy_q);
	c_rd_byte: cover property (done_q && rd_q);
	c_restart: cover property (state_q == ST_START && busy_q && $fell(sda_oe_n_q));
	c_hold: cover property ($rose(wr_busy));

endmodule // twm_master

`default_nettype wire

/* shared/twm_pkg.sv */
// Purpose: Constants and types shared by the two-wire master and its line filter
// Assumes: 10 MHz system clock, standard-mode bit rate on the serial link
// Notes:   All timing counts are derived from times held in their own units
`default_nettype none

package twm_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int SCL_PERIOD_NS = 10000;
	// Quarter of a bit period, rounded down so the bus never runs slow
	localparam int QUARTER_CYC = SCL_PERIOD_NS / 4 / CLK_PERIOD_NS;
	localparam logic [7:0] QCNT_LAST = 8'(QUARTER_CYC - 1);
	// Longest pulse the line filter must swallow
	localparam int GLITCH_NS = 50;
	localparam int GLITCH_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Memory internal write time, a least time so rounded up
	localparam int WRITE_CYCLE_NS = 5000000;
	localparam int WRITE_CYCLE_CYC = (WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Byte framing
	// ----------------------------------------------------------------
	localparam logic [3:0] MEM_SEL_TAG = 4'hA;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [1:0] PH_LAST = 2'h3;
	localparam logic [7:0] RD_RELEASE = 8'hFF;

	// Caller commands
	typedef enum logic [2:0] {
		CMD_START = 3'b000,
		CMD_STOP = 3'b001,
		CMD_WRITE = 3'b010,
		CMD_READ = 3'b011,
		CMD_SEL_WR = 3'b100,
		CMD_SEL_RD = 3'b101
	} cmd_t;

	// Bus sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_START = 2'b01,
		ST_BIT = 2'b10,
		ST_STOP = 2'b11
	} state_t;

endpackage

`default_nettype wire

/* shared/line_if.sv */
// Purpose: Carries the raw and filtered levels of the two bus lines
// Assumes: Bit 1 is the clock line, bit 0 the data line
// Notes:   Used only between the master and its filter
`default_nettype none

interface line_if;
	logic [1:0] raw;
	logic [1:0] clean;
	modport filt (input raw, output clean);
	modport user (output raw, input clean);
endinterface

`default_nettype wire

/* core/line_filter.sv */
// Purpose: Synchronise and de-glitch the bus line inputs
// Assumes: Lines idle high through external pull-ups
// Notes:   A level is taken once two successive synchronised samples agree
`default_nettype none

module line_filter
	import twm_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Lines
	line_if.filt lines
);

	logic [1:0] s1_q, s2_q, s3_q, clean_q, clean_d;

	// ----------------------------------------------------------------
	// Agreement filter
	// ----------------------------------------------------------------
	// Hold the old level until stages two and three agree
	always_comb begin
		clean_d = (s2_q & s3_q) | (clean_q & (s2_q | s3_q));
	end

	// Three-stage chain; first stage feeds only the second
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s1_q <= 2'h3;
			s2_q <= 2'h3;
			s3_q <= 2'h3;
			clean_q <= 2'h3;
		end else begin
			s1_q <= lines.raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			clean_q <= clean_d;
		end
	end

	assign lines.clean = clean_q;

	// A pulse must span two samples, wider than GLITCH_CYC, to pass
	property p_filt_agree;
		@(posedge sys_clk) disable iff (!rstn)
		// Checked line by line: the other line may be holding its old level
		(clean_q != $past(clean_q)) |->
			(((clean_q ^ $past(clean_q)) & ($past(s2_q) ^ $past(s3_q))) == 2'h0);
	endproperty
	a_filt_agree: assert property (p_filt_agree)
		else $error("filtered line changed without two agreeing samples");

endmodule // line_filter

`default_nettype wire

/* tb/mem_slave.sv */
// Purpose: Behavioural serial memory on the far side of the two-wire master
// Assumes: Bench resolves both lines with pull-ups; two address bytes
// Notes:   Refuse drops the ack of address and data bytes only
`default_nettype none

module mem_slave #(
	parameter int STRETCH_NS = 6000
) (
	// Lines
	input wire logic scl,
	input wire logic sda,
	// Controls
	input wire logic [2:0] chip,
	input wire logic refuse,
	input wire logic stretch,
	// Pulls
	output logic scl_low,
	output logic sda_low
);
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------
	// Framing state
	// ----------------
	logic [7:0] mem [logic [15:0]];
	logic [7:0] sh;
	logic [7:0] cur;
	logic [15:0] adr = 16'h0000;
	logic act = 1'b0;
	logic rd = 1'b0;
	int bitn = 0;
	int nbyte = 0;

	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end

	// Any start condition on the lines opens a frame, whoever pulls data low; stop closes it
	always @(negedge sda) if (scl) begin
		act = 1'b1;
		rd = 1'b0;
		bitn = 0;
		nbyte = 0;
	end
	always @(posedge sda) if (scl) act = 1'b0;

	// Bits are taken on the rising clock edge
	always @(posedge scl) if (act) begin
		if (bitn < 8) sh = {sh[6:0], sda};
		else if (rd && nbyte > 0 && sda) act = 1'b0;
		bitn++;
	end

	// Lines change only while the clock line is low, so no false start
	always @(negedge scl) if (act) begin
		if (bitn == 9) begin
			bitn = 0;
			nbyte++;
			sda_low = 1'b0;
		end
		if (bitn == 8) begin
			if (rd && nbyte > 0) begin
				sda_low = 1'b0;
				adr++;
			end else if (nbyte == 0) begin
				sda_low = (sh[7:1] == {4'hA, chip});
				rd = sh[0];
				if (!sda_low) act = 1'b0;
			end else if (refuse) begin
				act = 1'b0;
			end else begin
				sda_low = 1'b1;
				if (nbyte == 1) adr[15:8] = sh;
				else if (nbyte == 2) adr[7:0] = sh;
				else begin
					mem[adr] = sh;
					adr++;
				end
			end
		end else if (rd && nbyte > 0) begin
			cur = mem.exists(adr) ? mem[adr] : (adr[7:0] ^ adr[15:8] ^ 8'h3C);
			sda_low = !cur[7 - bitn];
		end
	end

	// Slow answer: hold the clock line low past the master's low time
	always @(negedge scl) if (stretch && act) begin
		scl_low = 1'b1;
		#(STRETCH_NS) scl_low = 1'b0;
	end
endmodule // mem_slave

`default_nettype wire

/* tb/two_wire_master_eeprom_access_test.sv */
// Purpose: Self-checking bench of the two-wire master with a memory model
// Assumes: Write hold cut to 20 cycles; random values from a fixed seed
// Notes:   Model memory is read by name to check the bit order on the wire
`default_nettype none

`define CHK(nm, e, g) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("unexpected %s: expected %h seen %h", nm, e, g); \
	end \
end

module two_wire_master_eeprom_access_test
	import twm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HOLD = 20;

	// ----------------
	// Signals
	// ----------------
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic cmd_valid = 1'b0;
	logic [2:0] cmd_code = 3'h0;
	logic [7:0] cmd_data = 8'h00;
	logic [2:0] cmd_chip = 3'h0;
	logic cmd_ack_bit = 1'b1;
	logic cmd_ready, done, nack, bus_idle, wr_busy;
	logic [7:0] rd_data;
	logic scl_out, scl_oe_n, sda_out, sda_oe_n, scl_low, sda_low;
	logic refuse = 1'b0;
	logic stretch = 1'b0;
	logic glitch = 1'b0;
	logic [2:0] mchip = 3'h0;
	logic [2:0] cchip = 3'h0;
	logic [7:0] shadow [logic [15:0]];
	wire scl_w, sda_w;
	int error_cnt = 0;
	int total_checks = 0;
	int seed = 48;
	int cycles = 0;
	int stops = 0;

	// Open-drain lines with pull-ups: low while any party pulls
	assign scl_w = !((!scl_oe_n && !scl_out) || scl_low);
	assign sda_w = !((!sda_oe_n && !sda_out) || sda_low || glitch);

	twm_master #(.WR_HOLD_CYC(HOLD)) i_dut (.sys_clk(sys_clk), .rstn(rstn),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
		.cmd_chip(cmd_chip), .cmd_ack_bit(cmd_ack_bit), .cmd_ready(cmd_ready),
		.done(done), .nack(nack), .rd_data(rd_data), .bus_idle(bus_idle),
		.wr_busy(wr_busy), .scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
		.sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
	mem_slave i_mem (.scl(scl_w), .sda(sda_w), .chip(mchip), .refuse(refuse),
		.stretch(stretch), .scl_low(scl_low), .sda_low(sda_low));

	initial begin
		forever #50 sys_clk = ~sys_clk;
	end

	// Stops seen on the wire, to tell a repeated start from stop and start
	always @(posedge sda_w) if (scl_w) stops++;

	// Cut a hang short
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 95000) begin
			error_cnt++;
			close_out();
		end
	end

	// ----------------
	// Tasks
	// ----------------
	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// One command: held until taken, then wait for its done pulse
	task automatic cmd(input logic [2:0] c, input logic [7:0] d, input logic ab);
		int n;
		n = 0;
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_data <= d;
		cmd_chip <= cchip;
		cmd_ack_bit <= ab;
		do begin
			@(posedge sys_clk);
			n++;
		end while (cmd_ready !== 1'b1 && n < 20000);
		cmd_valid <= 1'b0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (done !== 1'b1 && n < 20000);
		if (n >= 20000) error_cnt++;
	endtask

	function automatic logic [7:0] exp_at(input logic [15:0] a);
		return shadow.exists(a) ? shadow[a] : (a[7:0] ^ a[15:8] ^ 8'h3C);
	endfunction

	// Memory write; rf makes the memory refuse the data byte
	task automatic mem_write(input logic [15:0] a, input logic [7:0] d, input logic rf);
		int n;
		cmd(CMD_START, 8'h00, 1'b1);
		`CHK("idle after start", 1'b0, bus_idle)
		cmd(CMD_SEL_WR, 8'h00, 1'b1);
		`CHK("select ack", 1'b0, nack)
		cmd(CMD_WRITE, a[15:8], 1'b1);
		cmd(CMD_WRITE, a[7:0], 1'b1);
		refuse = rf;
		cmd(CMD_WRITE, d, 1'b1);
		`CHK("data ack", rf, nack)
		cmd(CMD_STOP, 8'h00, 1'b1);
		refuse = 1'b0;
		if (!rf) `CHK("stored byte", d, i_mem.mem[a])
		if (!rf) shadow[a] = d;
		@(posedge sys_clk);
		`CHK("hold running", 2'b10, {wr_busy, cmd_ready})
		n = 1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wr_busy !== 1'b0 && n < 200);
		`CHK("hold length", 1'b1, n >= HOLD - 2 && n <= HOLD + 3)
		`CHK("idle after stop", 1'b1, bus_idle)
	endtask

	// Random read, then more bytes in sequence; the last is not acked
	task automatic mem_read(input logic [15:0] a, input int cnt);
		int s0;
		cmd(CMD_START, 8'h00, 1'b1);
		cmd(CMD_SEL_WR, 8'h00, 1'b1);
		cmd(CMD_WRITE, a[15:8], 1'b1);
		cmd(CMD_WRITE, a[7:0], 1'b1);
		s0 = stops;
		cmd(CMD_START, 8'h00, 1'b1);
		`CHK("stops before restart", s0, stops)
		cmd(CMD_SEL_RD, 8'h00, 1'b1);
		`CHK("read select ack", 1'b0, nack)
		for (int i = 0; i < cnt; i++) begin
			cmd(CMD_READ, 8'h00, i == cnt - 1);
			`CHK("read byte", exp_at(a + 16'(i)), rd_data)
		end
		cmd(CMD_STOP, 8'h00, 1'b1);
		`CHK("stop after read", s0 + 1, stops)
	endtask

	// ----------------
	// Main sequence
	// ----------------
	initial begin
		logic [15:0] a;
		logic [7:0] d;
		int n0;
		repeat (12) @(posedge sys_clk);
		`CHK("released in reset", 2'b11, {scl_oe_n, sda_oe_n})
		`CHK("line levels", 2'b00, {scl_out, sda_out})
		rstn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		`CHK("idle after reset", 1'b1, bus_idle)
		cmd(CMD_WRITE, 8'h55, 1'b1);
		`CHK("byte without start", 1'b1, nack)
		// A stop with no transaction open only pulses done; nack keeps its value
		cmd(CMD_STOP, 8'h00, 1'b1);
		`CHK("lone stop", 1'b1, nack)
		`CHK("lone stop idle", 1'b1, bus_idle)
		cmd(3'h7, 8'h00, 1'b1);
		`CHK("unused code", 1'b1, bus_idle)
		// A 40 ns dip is swallowed, a long one is seen
		glitch <= 1'b1;
		#40 glitch <= 1'b0;
		repeat (6) @(posedge sys_clk) `CHK("short pulse", 1'b1, bus_idle)
		glitch <= 1'b1;
		repeat (8) @(posedge sys_clk);
		`CHK("long pulse", 1'b0, bus_idle)
		// A fresh start asked for while data is held low waits for an idle bus
		cchip = 3'h3;
		n0 = cycles;
		fork
			cmd(CMD_START, 8'h00, 1'b1);
			begin
				repeat (60) @(posedge sys_clk);
				glitch <= 1'b0;
			end
		join
		`CHK("start held off", 1'b1, (cycles - n0) > 60 + 3 * QUARTER_CYC)
		// Select byte with the wrong chip address is not acked
		cmd(CMD_SEL_RD, 8'h00, 1'b1);
		`CHK("wrong chip", 1'b1, nack)
		cmd(CMD_STOP, 8'h00, 1'b1);
		// Random traffic: second round stretched, third refused
		for (int k = 0; k < 3; k++) begin
			mchip = 3'($random(seed));
			cchip = mchip;
			a = 16'($random(seed));
			d = 8'($random(seed));
			stretch = (k == 1);
			mem_write(a, d, k == 2);
			mem_read(a - 16'h0001, 3);
		end
		close_out();
	end
endmodule // two_wire_master_eeprom_access_test

`default_nettype wire
